// >>> alc_map.svh
`ifndef ALC_MAP_SVH
`define ALC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define ALC_OFS_OFFICE_MAX   8'h07
`define ALC_OFS_OFFICE_DIM   8'h08
`define ALC_OFS_NIGHT_MAX    8'h09
`define ALC_OFS_NIGHT_DIM    8'h0A
`define ALC_OFS_PRESENT_CODE 8'h0B
`define ALC_OFS_COMPARE_CFG  8'h0C
`define ALC_OFS_OFFICE_TRIP  8'h0D
`define ALC_OFS_OFFICE_HYS   8'h0E
`define ALC_OFS_NIGHT_TRIP   8'h0F
`define ALC_OFS_NIGHT_HYS    8'h10

////////////////////////////////////////////////////////////////////////////////
// Field positions of the comparator configuration register, and the MSB of the code registers
`define ALC_CFG_SENSOR_FILTER_TIME_HI      7
`define ALC_CFG_SENSOR_FILTER_TIME_LO      5
`define ALC_CFG_FORCE        4
`define ALC_CFG_NIGHT_STAT   3
`define ALC_CFG_OFFICE_STAT  2
`define ALC_CFG_NIGHT_EN     1
`define ALC_CFG_OFFICE_EN    0
`define ALC_CODE_MSB         6

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define ALC_RST_CODE         7'h00
`define ALC_RST_SENSOR_FILTER_TIME         3'h0
`define ALC_RST_BIT          1'h0
`define ALC_RST_RDATA        8'h00

////////////////////////////////////////////////////////////////////////////////
// Sensor scaling: sensor word counts half-microamp steps
`define ALC_SENSE_W          11
`define ALC_OFFICE_PAD       3'h0

////////////////////////////////////////////////////////////////////////////////
// Timing: shortest filter time, in microseconds, and the clock rate
`define ALC_SENSOR_FILTER_TIME_BASE_US     80000
`define ALC_CLK_MHZ          25
`define ALC_SENSOR_FILTER_TIME_BASE_CYC    (`ALC_SENSOR_FILTER_TIME_BASE_US * `ALC_CLK_MHZ)
`define ALC_TIMER_W          32

`endif

// >>> alc_pkg.sv
`include "alc_map.svh"
`default_nettype none

package alc_pkg;

  typedef logic [`ALC_CODE_MSB:0] alc_code_t;

  typedef enum logic [1:0] {
    ALC_LVL_DAYLIGHT,
    ALC_LVL_OFFICE,
    ALC_LVL_DARK
  } alc_level_e;

  typedef enum logic {
    ALC_SEQ_IDLE,
    ALC_SEQ_CONVERT
  } alc_seq_e;

  typedef struct packed {
    logic                    busy;
    logic                    done;
    logic [`ALC_TIMER_W-1:0] count;
  } alc_timer_s;

  typedef struct packed {
    logic [`ALC_SENSE_W-1:0] sens_meta;
    logic [`ALC_SENSE_W-1:0] sens_sync;
    alc_code_t               office_max;
    alc_code_t               office_dim;
    alc_code_t               night_max;
    alc_code_t               night_dim;
    alc_code_t               office_trip;
    alc_code_t               office_hys;
    alc_code_t               night_trip;
    alc_code_t               night_hys;
    logic [2:0]              sensor_filter_time;
    logic                    force_conv;
    logic                    night_status;
    logic                    office_status;
    logic                    night_en;
    logic                    office_en;
    alc_seq_e                seq;
    logic                    start;
    alc_level_e              level;
    alc_code_t               bl_code;
    logic [7:0]              rdata;
  } alc_state_s;

endpackage : alc_pkg

`default_nettype wire

// >>> alc_filter_timer.sv
`include "alc_map.svh"
`default_nettype none

// Counts one sensor filter window; the length doubles with each code step.
module alc_filter_timer #(
  parameter int unsigned BASE_CYCLES = `ALC_SENSOR_FILTER_TIME_BASE_CYC
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [2:0] code_i,
  // Status
  output logic            busy_o,
  output logic            done_o
);

  alc_pkg::alc_timer_s cur;
  alc_pkg::alc_timer_s next_cur;

  logic [`ALC_TIMER_W-1:0] base_w;
  logic [`ALC_TIMER_W-1:0] load_w;

  assign base_w = `ALC_TIMER_W'(BASE_CYCLES);
  assign load_w = base_w << code_i;

  always_comb begin
    next_cur      = cur;
    next_cur.done = 1'h0;
    if (start_i) begin
      // A restart always wins so a stale window never reports done
      next_cur.busy  = 1'h1;
      next_cur.count = load_w - `ALC_TIMER_W'(1);
    end else if (cur.busy) begin
      if (cur.count == '0) begin
        next_cur.busy = 1'h0;
        next_cur.done = 1'h1;
      end else begin
        next_cur.count = cur.count - `ALC_TIMER_W'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign busy_o = cur.busy;
  assign done_o = cur.done;

endmodule : alc_filter_timer

`default_nettype wire

// >>> alc_light_compare.sv
// Behaviour
// - Keep office and dark max codes, pick active
// - Keep office and dark dim codes, use dimmed
// - Read-only present backlight code, writes ignored
// - Filter time doubles from 0.08 s to 10.24 s
// - Writing force bit runs exactly one conversion
// - Force bit self-clears when conversion completes
// - Dark status set on office-to-dark move
// - Office status set on daylight-to-office move
// - Dark comparator works only while enabled
// - Office comparator works only while enabled
// - Auto adjust needs auto bit plus enables
// - Office status sets below office trip
// - Office status clears above trip plus hysteresis
// - Dark status sets below dark trip, 0.5uA
// - Office codes weigh four microamps per step
// - Dark status clears above trip plus hysteresis
`include "alc_map.svh"
`default_nettype none

module alc_light_compare #(
  parameter int unsigned FILTER_BASE_CYCLES = `ALC_SENSOR_FILTER_TIME_BASE_CYC
) (
  // Clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  // Register port from the serial interface engine
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [7:0]                     reg_rdata_o,
  // Ambient light sensor front end
  input  wire logic [`ALC_SENSE_W-1:0]   sensor_level_i,
  // Backlight control context
  input  wire logic                      auto_adjust_enable_i,
  input  wire logic                      dimmed_i,
  input  wire alc_pkg::alc_level_e       manual_level_i,
  input  wire alc_pkg::alc_code_t        daylight_max_i,
  input  wire alc_pkg::alc_code_t        daylight_dim_i,
  // Results
  output alc_pkg::alc_code_t             backlight_code_o,
  output alc_pkg::alc_level_e            ambient_level_select_o,
  output logic                           office_status_o,
  output logic                           night_status_o,
  output logic                           convert_busy_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // The timer shifts the base count left by up to seven places
  if (FILTER_BASE_CYCLES < 1 || FILTER_BASE_CYCLES > (1 << 24)) begin : g_bad_base
    $error("FILTER_BASE_CYCLES out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_pipe;
  logic       rst_sync_n;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end

  assign rst_sync_n = rst_pipe[1];

  //////////////////////////////////////////////////////////////////////////////
  // State

  localparam alc_pkg::alc_state_s RESET_STATE = '{
    sens_meta:     '0,
    sens_sync:     '0,
    office_max:    `ALC_RST_CODE,
    office_dim:    `ALC_RST_CODE,
    night_max:     `ALC_RST_CODE,
    night_dim:     `ALC_RST_CODE,
    office_trip:   `ALC_RST_CODE,
    office_hys:    `ALC_RST_CODE,
    night_trip:    `ALC_RST_CODE,
    night_hys:     `ALC_RST_CODE,
    sensor_filter_time:          `ALC_RST_SENSOR_FILTER_TIME,
    force_conv:    `ALC_RST_BIT,
    night_status:  `ALC_RST_BIT,
    office_status: `ALC_RST_BIT,
    night_en:      `ALC_RST_BIT,
    office_en:     `ALC_RST_BIT,
    seq:           alc_pkg::ALC_SEQ_IDLE,
    start:         `ALC_RST_BIT,
    level:         alc_pkg::ALC_LVL_DAYLIGHT,
    bl_code:       `ALC_RST_CODE,
    rdata:         `ALC_RST_RDATA
  };

  alc_pkg::alc_state_s cur;
  alc_pkg::alc_state_s next_cur;

  logic timer_done;

  //////////////////////////////////////////////////////////////////////////////
  // Filter window timer

  alc_filter_timer #(
    .BASE_CYCLES (FILTER_BASE_CYCLES)
  ) u_alc_filter_timer (
    .clock_i     (clock_i),
    .rst_n_i     (rst_sync_n),
    .start_i     (cur.start),
    .code_i      (cur.sensor_filter_time),
    .busy_o      (),
    .done_o      (timer_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Thresholds, all in half-microamp steps of the sensor word

  logic [`ALC_SENSE_W-1:0] office_set_lvl;
  logic [`ALC_SENSE_W-1:0] office_clr_lvl;
  logic [`ALC_SENSE_W-1:0] night_set_lvl;
  logic [`ALC_SENSE_W-1:0] night_clr_lvl;
  logic [7:0]              office_sum;
  logic [7:0]              night_sum;

  assign office_sum     = {1'h0, cur.office_trip} + {1'h0, cur.office_hys};
  assign night_sum      = {1'h0, cur.night_trip} + {1'h0, cur.night_hys};
  // An office step is eight times a dark step
  assign office_set_lvl = {1'h0, cur.office_trip, `ALC_OFFICE_PAD};
  assign office_clr_lvl = {office_sum, `ALC_OFFICE_PAD};
  assign night_set_lvl  = {4'h0, cur.night_trip};
  assign night_clr_lvl  = {3'h0, night_sum};

  //////////////////////////////////////////////////////////////////////////////
  // Read mux

  function automatic logic [7:0] read_word(
    input alc_pkg::alc_state_s st,
    input logic [7:0]          addr
  );
    logic [7:0] word;
    word = 8'h00;
    case (addr)
      `ALC_OFS_OFFICE_MAX: begin
        word = {1'h0, st.office_max};
      end
      `ALC_OFS_OFFICE_DIM: begin
        word = {1'h0, st.office_dim};
      end
      `ALC_OFS_NIGHT_MAX: begin
        word = {1'h0, st.night_max};
      end
      `ALC_OFS_NIGHT_DIM: begin
        word = {1'h0, st.night_dim};
      end
      `ALC_OFS_PRESENT_CODE: begin
        word = {1'h0, st.bl_code};
      end
      `ALC_OFS_COMPARE_CFG: begin
        word[`ALC_CFG_SENSOR_FILTER_TIME_HI:`ALC_CFG_SENSOR_FILTER_TIME_LO] = st.sensor_filter_time;
        word[`ALC_CFG_FORCE]       = st.force_conv;
        word[`ALC_CFG_NIGHT_STAT]  = st.night_status;
        word[`ALC_CFG_OFFICE_STAT] = st.office_status;
        word[`ALC_CFG_NIGHT_EN]    = st.night_en;
        word[`ALC_CFG_OFFICE_EN]   = st.office_en;
      end
      `ALC_OFS_OFFICE_TRIP: begin
        word = {1'h0, st.office_trip};
      end
      `ALC_OFS_OFFICE_HYS: begin
        word = {1'h0, st.office_hys};
      end
      `ALC_OFS_NIGHT_TRIP: begin
        word = {1'h0, st.night_trip};
      end
      `ALC_OFS_NIGHT_HYS: begin
        word = {1'h0, st.night_hys};
      end
      default: begin
        word = 8'h00;
      end
    endcase
    return word;
  endfunction : read_word

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic                 cfg_wr;
    logic                 force_wr;
    logic                 any_en;
    logic                 conv_done;
    logic                 auto_on;
    alc_pkg::alc_level_e  lvl;
    alc_pkg::alc_code_t   code;

    cfg_wr    = reg_wr_i && (reg_addr_i == `ALC_OFS_COMPARE_CFG);
    force_wr  = cfg_wr && reg_wdata_i[`ALC_CFG_FORCE];
    any_en    = cur.office_en || cur.night_en;
    // A done that lands on a restart belongs to the abandoned window
    conv_done = timer_done && !cur.start;
    auto_on   = auto_adjust_enable_i && any_en;
    lvl       = manual_level_i;
    code      = daylight_max_i;

    next_cur       = cur;
    next_cur.start = 1'h0;

    // The sensor word must hold steady across a window, so a plain
    // two-stage capture is enough here
    next_cur.sens_meta = sensor_level_i;
    next_cur.sens_sync = cur.sens_meta;

    // Register writes; bit 7 of every code register is dropped
    if (reg_wr_i) begin
      case (reg_addr_i)
        `ALC_OFS_OFFICE_MAX: begin
          next_cur.office_max = reg_wdata_i[`ALC_CODE_MSB:0];
        end
        `ALC_OFS_OFFICE_DIM: begin
          next_cur.office_dim = reg_wdata_i[`ALC_CODE_MSB:0];
        end
        `ALC_OFS_NIGHT_MAX: begin
          next_cur.night_max = reg_wdata_i[`ALC_CODE_MSB:0];
        end
        `ALC_OFS_NIGHT_DIM: begin
          next_cur.night_dim = reg_wdata_i[`ALC_CODE_MSB:0];
        end
        `ALC_OFS_COMPARE_CFG: begin
          next_cur.sensor_filter_time      = reg_wdata_i[`ALC_CFG_SENSOR_FILTER_TIME_HI:`ALC_CFG_SENSOR_FILTER_TIME_LO];
          next_cur.night_en  = reg_wdata_i[`ALC_CFG_NIGHT_EN];
          next_cur.office_en = reg_wdata_i[`ALC_CFG_OFFICE_EN];
        end
        `ALC_OFS_OFFICE_TRIP: begin
          next_cur.office_trip = reg_wdata_i[`ALC_CODE_MSB:0];
        end
        `ALC_OFS_OFFICE_HYS: begin
          next_cur.office_hys = reg_wdata_i[`ALC_CODE_MSB:0];
        end
        `ALC_OFS_NIGHT_TRIP: begin
          next_cur.night_trip = reg_wdata_i[`ALC_CODE_MSB:0];
        end
        `ALC_OFS_NIGHT_HYS: begin
          next_cur.night_hys = reg_wdata_i[`ALC_CODE_MSB:0];
        end
        default: begin
          // Present code and unmapped offsets take no write
        end
      endcase
    end

    // Conversion sequencer
    case (cur.seq)
      alc_pkg::ALC_SEQ_IDLE: begin
        if (cur.force_conv || any_en) begin
          next_cur.start = 1'h1;
          next_cur.seq   = alc_pkg::ALC_SEQ_CONVERT;
        end
      end
      alc_pkg::ALC_SEQ_CONVERT: begin
        if (force_wr) begin
          // A fresh request gets a full window of its own
          next_cur.start = 1'h1;
        end else if (conv_done) begin
          next_cur.seq = alc_pkg::ALC_SEQ_IDLE;
          next_cur.force_conv = 1'h0;
          if (cur.office_en) begin
            if (cur.sens_sync < office_set_lvl) begin
              next_cur.office_status = 1'h1;
            end else if (cur.sens_sync > office_clr_lvl) begin
              next_cur.office_status = 1'h0;
            end
          end
          if (cur.night_en) begin
            if (cur.sens_sync < night_set_lvl) begin
              next_cur.night_status = 1'h1;
            end else if (cur.sens_sync > night_clr_lvl) begin
              next_cur.night_status = 1'h0;
            end
          end
        end else if (!cur.force_conv && !any_en) begin
          next_cur.seq = alc_pkg::ALC_SEQ_IDLE;
        end
      end
      default: begin
        next_cur.seq = alc_pkg::ALC_SEQ_IDLE;
      end
    endcase

    // Set wins over the sequencer's clear
    if (force_wr) begin
      next_cur.force_conv = 1'h1;
    end

    // Ambient level: comparators steer it only under automatic adjust
    if (auto_on) begin
      if (cur.night_en && cur.night_status) begin
        lvl = alc_pkg::ALC_LVL_DARK;
      end else if (cur.office_en && cur.office_status) begin
        lvl = alc_pkg::ALC_LVL_OFFICE;
      end else begin
        lvl = alc_pkg::ALC_LVL_DAYLIGHT;
      end
    end

    case (lvl)
      alc_pkg::ALC_LVL_OFFICE: begin
        code = dimmed_i ? cur.office_dim : cur.office_max;
      end
      alc_pkg::ALC_LVL_DARK: begin
        code = dimmed_i ? cur.night_dim : cur.night_max;
      end
      default: begin
        code = dimmed_i ? daylight_dim_i : daylight_max_i;
      end
    endcase

    next_cur.level   = lvl;
    next_cur.bl_code = code;

    if (reg_rd_i) begin
      next_cur.rdata = read_word(cur, reg_addr_i);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur <= RESET_STATE;
    end else begin
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Busy is taken from the sequencer so the output stays a flop
  assign reg_rdata_o            = cur.rdata;
  assign backlight_code_o       = cur.bl_code;
  assign ambient_level_select_o = cur.level;
  assign office_status_o        = cur.office_status;
  assign night_status_o         = cur.night_status;
  assign convert_busy_o         = (cur.seq == alc_pkg::ALC_SEQ_CONVERT) ? 1'h1 : 1'h0;

endmodule : alc_light_compare

`default_nettype wire

// >>> alc_light_compare_props.sv
`include "alc_map.svh"
`default_nettype none

module alc_light_compare_props #(
  parameter int unsigned FILTER_BASE_CYCLES = `ALC_SENSOR_FILTER_TIME_BASE_CYC
) (
  // Clock and reset
  input wire logic                    clock_i,
  input wire logic                    rst_n_i,
  // Register port
  input wire logic [7:0]              reg_addr_i,
  input wire logic [7:0]              reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [7:0]              reg_rdata_o,
  // Sensor and backlight context
  input wire logic [`ALC_SENSE_W-1:0] sensor_level_i,
  input wire logic                    auto_adjust_enable_i,
  input wire logic                    dimmed_i,
  input wire alc_pkg::alc_level_e     manual_level_i,
  input wire alc_pkg::alc_code_t      daylight_max_i,
  input wire alc_pkg::alc_code_t      daylight_dim_i,
  // Results
  input wire alc_pkg::alc_code_t      backlight_code_o,
  input wire alc_pkg::alc_level_e     ambient_level_select_o,
  input wire logic                    office_status_o,
  input wire logic                    night_status_o,
  input wire logic                    convert_busy_o
);
  // Top filter code plus sequencer overhead; a restart would need its own bound
  localparam int MAX_WIN = FILTER_BASE_CYCLES * 128 + 8;

  logic [2:0] up_q;
  logic       up;

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs lag the synchronised reset, so output checks wait it out
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h4) begin
      up_q <= up_q + 3'h1;
    end
  end
  assign up = (up_q == 3'h4);

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////////
  property p_day_max;
    up && ambient_level_select_o == alc_pkg::ALC_LVL_DAYLIGHT && !dimmed_i
      && $stable(dimmed_i) && $stable(ambient_level_select_o) && $stable(daylight_max_i)
      |-> backlight_code_o == daylight_max_i;
  endproperty
  a_day_max: assert property (p_day_max)
    else $error("daylight max code not applied");
  property p_day_dim;
    up && ambient_level_select_o == alc_pkg::ALC_LVL_DAYLIGHT && dimmed_i
      && $stable(dimmed_i) && $stable(ambient_level_select_o) && $stable(daylight_dim_i)
      |-> backlight_code_o == daylight_dim_i;
  endproperty
  a_day_dim: assert property (p_day_dim)
    else $error("daylight dim code not applied");
  property p_rd_code;
    reg_rd_i && reg_addr_i == 8'h0B |=> reg_rdata_o == {1'b0, $past(backlight_code_o)};
  endproperty
  a_rd_code: assert property (p_rd_code)
    else $error("present code read mismatch");
  property p_win_min;
    $rose(convert_busy_o) |-> convert_busy_o[*4];
  endproperty
  a_win_min: assert property (p_win_min)
    else $error("conversion window too short");
  property p_win_max;
    $rose(convert_busy_o) |-> ##[1:MAX_WIN] !convert_busy_o;
  endproperty
  a_win_max: assert property (p_win_max)
    else $error("conversion never completed");
  property p_off_chg;
    $changed(office_status_o) |-> $fell(convert_busy_o);
  endproperty
  a_off_chg: assert property (p_off_chg)
    else $error("office status moved outside a completion");
  property p_ngt_chg;
    $changed(night_status_o) |-> $fell(convert_busy_o);
  endproperty
  a_ngt_chg: assert property (p_ngt_chg)
    else $error("night status moved outside a completion");
  property p_rd_off;
    reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o[2] == $past(office_status_o);
  endproperty
  a_rd_off: assert property (p_rd_off)
    else $error("office status read mismatch");
  property p_rd_ngt;
    reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o[3] == $past(night_status_o);
  endproperty
  a_rd_ngt: assert property (p_rd_ngt)
    else $error("night status read mismatch");
  property p_bit7;
    reg_rd_i && reg_addr_i inside {[8'h07:8'h0B], [8'h0D:8'h10]} |=> !reg_rdata_o[7];
  endproperty
  a_bit7: assert property (p_bit7)
    else $error("unused bit 7 read as one");
  property p_manual;
    up && !auto_adjust_enable_i && manual_level_i != 2'h3
      |=> ambient_level_select_o == $past(manual_level_i);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual level not followed");

  c_conv: cover property ($fell(convert_busy_o));
  c_dark: cover property (ambient_level_select_o == alc_pkg::ALC_LVL_DARK);
  c_off: cover property ($rose(office_status_o));

endmodule : alc_light_compare_props

bind alc_light_compare alc_light_compare_props #(
  .FILTER_BASE_CYCLES(FILTER_BASE_CYCLES)
) u_alc_light_compare_props (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .sensor_level_i(sensor_level_i), .auto_adjust_enable_i(auto_adjust_enable_i),
  .dimmed_i(dimmed_i), .manual_level_i(manual_level_i), .daylight_max_i(daylight_max_i),
  .daylight_dim_i(daylight_dim_i), .backlight_code_o(backlight_code_o),
  .ambient_level_select_o(ambient_level_select_o), .office_status_o(office_status_o),
  .night_status_o(night_status_o), .convert_busy_o(convert_busy_o)
);

`default_nettype wire

// >>> alc_host_model.sv
`default_nettype none

module alc_host_model (
  // Clock
  input  wire logic       clock_i,
  // Register port
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // Idle address and data show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clock_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clock_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    q          = reg_rdata_i;
  endtask : rd

endmodule : alc_host_model

`default_nettype wire

// >>> alc_light_compare_tb_top.sv
`include "alc_map.svh"
`default_nettype none

module alc_light_compare_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned BASE = 4;

  logic                    clock       = 1'b0;
  logic                    rst_n       = 1'b0;
  logic [`ALC_SENSE_W-1:0] sensor      = 11'h000;
  logic                    auto_adj    = 1'b0;
  logic                    dimmed      = 1'b0;
  alc_pkg::alc_level_e     manual      = alc_pkg::ALC_LVL_DAYLIGHT;
  logic [7:0]              addr;
  logic [7:0]              wdata;
  logic                    wr;
  logic                    rd;
  logic [7:0]              rdata;
  alc_pkg::alc_code_t      code;
  alc_pkg::alc_level_e     level;
  logic                    off_st;
  logic                    ngt_st;
  logic                    busy;
  int                      failures    = 0;
  int                      checks_done = 0;
  int                      done_cnt    = 0;
  logic [7:0] ofs [8] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h10};
  logic [7:0] val [8] = '{8'h21, 8'h22, 8'h31, 8'h32, 8'h10, 8'h04, 8'h20, 8'h08};
  logic [7:0] man_exp [6] = '{8'h15, 8'h16, 8'h21, 8'h22, 8'h31, 8'h32};
  // Office edges at 128 and 160 sensor units, night edges at 32 and 40
  logic [10:0] snz [8] = '{11'h080, 11'h07F, 11'h020, 11'h01F,
                           11'h028, 11'h029, 11'h0A0, 11'h0A1};
  logic [7:0] st_exp [8] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h03, 8'h01, 8'h01, 8'h00};
  logic [7:0] cd_exp [8] = '{8'h15, 8'h21, 8'h21, 8'h31, 8'h31, 8'h21, 8'h21, 8'h15};

  always #20 clock = ~clock;
  always @(negedge busy) done_cnt++;

  alc_light_compare #(
    .FILTER_BASE_CYCLES(BASE)
  ) u_alc_light_compare (
    .clock_i(clock), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sensor_level_i(sensor),
    .auto_adjust_enable_i(auto_adj), .dimmed_i(dimmed), .manual_level_i(manual),
    .daylight_max_i(7'h15), .daylight_dim_i(7'h16), .backlight_code_o(code),
    .ambient_level_select_o(level), .office_status_o(off_st), .night_status_o(ngt_st),
    .convert_busy_o(busy)
  );

  alc_host_model u_alc_host_model (
    .clock_i(clock), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    u_alc_host_model.rd(a, got);
    chk(got, exp);
  endtask : rdc

  // Two completions so the sensor change has passed its synchroniser
  task automatic wait_conv();
    int s;
    s = done_cnt;
    repeat (3000) if (done_cnt < s + 2) @(negedge clock);
    if (done_cnt < s + 2) failures++;
    repeat (2) @(negedge clock);
  endtask : wait_conv

  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    // Forced single conversions, comparators off, dark sensor
    for (int c = 0; c < 4; c++) begin
      int n;
      n = 0;
      u_alc_host_model.wr(8'h0C, {c[2:0], 5'h10});
      repeat (80) begin
        @(negedge clock);
        if (busy === 1'b1) n++;
      end
      chk({7'h00, n >= (BASE << c) && n <= (BASE << c) + 5}, 8'h01);
      rdc(8'h0C, {c[2:0], 5'h00});
    end
    foreach (ofs[i]) begin
      rdc(ofs[i], 8'h00);
      u_alc_host_model.wr(ofs[i], 8'hFF);
      rdc(ofs[i], 8'h7F);
      u_alc_host_model.wr(ofs[i], val[i]);
      rdc(ofs[i], val[i]);
    end
    u_alc_host_model.wr(8'h0B, 8'h5A);
    rdc(8'h0B, 8'h15);
    rdc(8'h11, 8'h00);
    for (int l = 0; l < 6; l++) begin
      manual = alc_pkg::alc_level_e'(l / 2);
      dimmed = l[0];
      repeat (2) @(negedge clock);
      chk({1'b0, code}, man_exp[l]);
      rdc(8'h0B, man_exp[l]);
    end
    manual   = alc_pkg::ALC_LVL_DAYLIGHT;
    dimmed   = 1'b0;
    auto_adj = 1'b1;
    u_alc_host_model.wr(8'h0C, 8'h03);
    foreach (snz[i]) begin
      sensor = snz[i];
      wait_conv();
      chk({6'h00, ngt_st, off_st}, st_exp[i]);
      chk({1'b0, code}, cd_exp[i]);
      rdc(8'h0C, {4'h0, st_exp[i][1:0], 2'h3});
    end
    // A disabled comparator must hold its status whatever the light does
    u_alc_host_model.wr(8'h0C, 8'h01);
    sensor = 11'h000;
    wait_conv();
    chk({6'h00, ngt_st, off_st}, 8'h01);
    // Office status is set and enabled, but with the auto bit off the manual level rules
    auto_adj = 1'b0;
    repeat (2) @(negedge clock);
    chk({6'h00, level}, 8'h00);
    auto_adj = 1'b1;
    u_alc_host_model.wr(8'h0C, 8'h02);
    sensor = 11'h7FF;
    wait_conv();
    chk({6'h00, ngt_st, off_st}, 8'h01);
    chk({6'h00, level}, 8'h00);
    tally_and_finish();
  end

  initial begin
    #(40 * 20000);
    failures++;
    tally_and_finish();
  end

endmodule : alc_light_compare_tb_top

`default_nettype wire
